// ===== adcc_pkg.sv
// Shared constants, types and helpers for the converter control block.
// Assumes a single 10 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package adcc_pkg;

  // Clock and conversion timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TAD_NS        = 2000;
  // Least time, so the cycle count rounds up
  localparam int TAD_CYC       = (TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TADS     = 11;
  localparam int ABORT_TADS    = 2;
  localparam int RES_W         = 10;

  // Register byte offsets on the bus
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_RES_HIGH  = 8'h04;
  localparam logic [7:0]  OFS_RES_LOW   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h14;

  // Control register layout and reset
  localparam int         BIT_JUSTIFY  = 7;
  localparam int         BIT_REF_EXT  = 6;
  localparam int         BIT_CHAN_LO  = 2;
  localparam int         BIT_GO       = 1;
  localparam int         BIT_POWER    = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CTRL_WMASK   = 8'hcf;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Interrupt status layout
  localparam int         IRQ_W        = 1;
  localparam int         IRQ_DONE_BIT = 0;
  localparam logic [0:0] IRQ_RESET    = 1'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       justify;
    logic       ref_ext;
    logic [1:0] unused;
    logic [1:0] channel;
    logic       go;
    logic       power;
  } adcc_ctrl_s;

  typedef enum logic [2:0] {
    SAR_IDLE = 3'b001,
    SAR_CONV = 3'b010,
    SAR_HOLD = 3'b100
  } adcc_sar_e;

  // Returns {high byte, low byte} for the chosen justification
  function automatic logic [15:0] adcc_format(input logic [9:0] res,
                                              input logic       right);
    if (right) begin
      adcc_format = {6'h00, res[9:8], res[7:0]};
    end else begin
      adcc_format = {res[9:2], res[1:0], 6'h00};
    end
  endfunction

endpackage

`default_nettype wire

// ===== adcc_sar.sv
// Successive-approximation sequencer: one sample period then ten bit trials.
// Assumes a one-cycle bit-period enable and a synchronised comparator level.
`timescale 1ns/1ps
`default_nettype none

module adcc_sar (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  // Control
  input  wire logic                      tad_tick,
  input  wire logic                      start,
  input  wire logic                      abort,
  input  wire logic                      cmp_hi,
  // Status and analog drive
  output logic                           done,
  output logic                           holdoff,
  output logic [adcc_pkg::RES_W-1:0]     result,
  output logic [adcc_pkg::RES_W-1:0]     dac_code,
  output logic                           sample_on
);
  import adcc_pkg::*;

  adcc_sar_e  state_r;
  logic [3:0] tad_cnt_r;
  logic [3:0] bit_pos;
  logic [9:0] trial;

  // Bit under test walks from 9 down to 0 over bit periods 1..10
  assign bit_pos = 4'(CONV_TADS - 1) - tad_cnt_r;

  // Keep or drop the bit under test, then try the next lower one
  always_comb begin
    trial = dac_code;
    if (tad_cnt_r != 4'h0) begin
      trial[bit_pos] = cmp_hi;
      if (bit_pos != 4'h0) begin
        trial[bit_pos - 4'h1] = 1'b1;
      end
    end
  end

  // Sequencer; an abort beats a finishing trial so no partial result lands
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r   <= SAR_IDLE;
      tad_cnt_r <= 4'h0;
      dac_code  <= 10'h000;
      sample_on <= 1'b0;
      done      <= 1'b0;
      result    <= 10'h000;
    end else begin
      done <= 1'b0;
      case (state_r)
        SAR_IDLE: begin
          if (start) begin
            state_r   <= SAR_CONV;
            tad_cnt_r <= 4'h0;
            dac_code  <= 10'h200;
            sample_on <= 1'b1;
          end
        end
        SAR_CONV: begin
          if (abort) begin
            state_r   <= SAR_HOLD;
            tad_cnt_r <= 4'h0;
            sample_on <= 1'b0;
          end else if (tad_tick) begin
            sample_on <= 1'b0;
            dac_code  <= trial;
            tad_cnt_r <= tad_cnt_r + 4'h1;
            if (tad_cnt_r == 4'(CONV_TADS - 1)) begin
              result  <= trial;
              done    <= 1'b1;
              state_r <= SAR_IDLE;
            end
          end
        end
        SAR_HOLD: begin
          // Settling gap after an abort before a new acquisition
          if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
            if (tad_cnt_r == 4'(ABORT_TADS - 1)) begin
              state_r <= SAR_IDLE;
            end
          end
        end
        default: begin
          state_r <= SAR_IDLE;
        end
      endcase
    end
  end

  assign holdoff = (state_r == SAR_HOLD);

endmodule

`default_nettype wire

// ===== adcc_top.sv
// Converter control block: AXI4-Lite registers, analog front-end drive,
// bit-period divider, conversion-done interrupt.
// Assumes the analog mux, reference switch, DAC and comparator sit outside;
// the comparator level arrives asynchronously.
//
// What this block does
// - Justify bit one gives right-justified result, zero gives left-justified.
// - Reference bit one selects external reference pin, zero selects supply.
// - Control bits five and four read zero and ignore writes.
// - Two-bit channel field routes input zero to three to the converter.
// - Writing one to trigger bit, with enable bit already one and kept one, starts conversion outside the abort wait; bit reads one meanwhile.
// - Hardware clears trigger bit when conversion ends; zero means idle.
// - Enable bit powers converter; zero shuts it off completely.
// - Completion clears trigger, sets done flag, loads both result bytes.
// - Early trigger clear aborts, keeps old result, waits two bit periods.
// - Right justified: bits nine, eight in high byte, rest in low byte.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module adcc_top (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [adcc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [adcc_pkg::ADDR_W-1:0]   s_axi_araddr,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // Analog front end
  input  wire logic                          comparator_in,
  output logic                               converter_power_enable,
  output logic                               reference_source_select,
  output logic [1:0]                         input_channel_select,
  output logic                               sample_switch_on,
  output logic [adcc_pkg::RES_W-1:0]         dac_code,
  // Interrupt
  output logic                               irq
);
  import adcc_pkg::*;

  // Register state
  adcc_ctrl_s        ctrl_r;
  logic [7:0]        res_high_r;
  logic [7:0]        res_low_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_en_r;

  // Bus channel state
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic              wstrb0_r;

  // Comparator synchroniser
  logic              cmp_meta_r;
  logic              cmp_sync_r;

  // Bit-period divider
  logic [7:0]        tad_div_r;
  logic              tad_tick_r;

  // Sequencer handshake
  logic              sar_start;
  logic              sar_abort;
  logic              sar_done;
  logic              sar_holdoff;
  logic [RES_W-1:0]  sar_result;
  logic [15:0]       fmt;

  // Write decode
  logic              wr_fire;
  logic              wr_ctrl;
  logic              wr_irq_clr;
  logic              wr_irq_en;
  logic              wr_mapped;
  adcc_ctrl_s        ctrl_wr;
  logic              start_req;
  logic              abort_req;

  // Read decode
  logic              rd_fire;
  logic              rd_mapped;
  logic [7:0]        rd_byte;

  // A write fires once both the address and the data have been captured
  assign wr_fire    = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ctrl    = wr_fire && wstrb0_r && (awaddr_r == OFS_CONTROL);
  assign wr_irq_clr = wr_fire && wstrb0_r && (awaddr_r == OFS_IRQ_CLEAR);
  assign wr_irq_en  = wr_fire && wstrb0_r && (awaddr_r == OFS_IRQ_EN);

  // Result registers take writes silently; only unknown offsets error
  always_comb begin
    case (awaddr_r)
      OFS_CONTROL, OFS_RES_HIGH, OFS_RES_LOW,
      OFS_IRQ_STAT, OFS_IRQ_CLEAR, OFS_IRQ_EN: wr_mapped = 1'b1;
      default:                                 wr_mapped = 1'b0;
    endcase
  end

  // Unimplemented bits are masked so they can never be stored
  assign ctrl_wr = adcc_ctrl_s'(wdata_r[7:0] & CTRL_WMASK);

  // A start needs the converter already on before this write and kept on;
  // a start set together with power-up is dropped and reads back zero.
  // Starts during the post-abort gap are dropped the same way.
  assign start_req = wr_ctrl && ctrl_wr.go && !ctrl_r.go
                     && ctrl_wr.power && ctrl_r.power
                     && !sar_holdoff;

  // Clearing the trigger or the power mid-conversion aborts it
  assign abort_req = wr_ctrl && ctrl_r.go
                     && (!ctrl_wr.go || !ctrl_wr.power);

  assign sar_start = start_req;
  assign sar_abort = abort_req;

  // Write address channel capture
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  // Write data channel capture; only byte lane 0 carries register bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // Ready is registered so the handshake never loops through the master
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                       && !wr_fire && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                       && !wr_fire && !s_axi_bvalid;
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Static control fields: justify, reference, channel, power
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_r.justify <= CTRL_RESET[BIT_JUSTIFY];
      ctrl_r.ref_ext <= CTRL_RESET[BIT_REF_EXT];
      ctrl_r.unused  <= 2'h0;
      ctrl_r.channel <= CTRL_RESET[BIT_CHAN_LO +: 2];
      ctrl_r.power   <= CTRL_RESET[BIT_POWER];
    end else if (wr_ctrl) begin
      ctrl_r.justify <= ctrl_wr.justify;
      ctrl_r.ref_ext <= ctrl_wr.ref_ext;
      ctrl_r.unused  <= 2'h0;
      ctrl_r.channel <= ctrl_wr.channel;
      ctrl_r.power   <= ctrl_wr.power;
    end
  end

  // Trigger/status bit: set by an accepted start, held through the
  // conversion, dropped by completion or abort
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_r.go <= CTRL_RESET[BIT_GO];
    end else if (start_req) begin
      ctrl_r.go <= 1'b1;
    end else if (sar_done || abort_req) begin
      ctrl_r.go <= 1'b0;
    end
  end

  // Result bytes load only on a full conversion, formatted at that moment
  assign fmt = adcc_format(sar_result, ctrl_r.justify);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      res_high_r <= RESULT_RESET;
      res_low_r  <= RESULT_RESET;
    end else if (sar_done) begin
      res_high_r <= fmt[15:8];
      res_low_r  <= fmt[7:0];
    end
  end

  // Done flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_stat_r <= IRQ_RESET;
    end else if (sar_done) begin
      irq_stat_r[IRQ_DONE_BIT] <= 1'b1;
    end else if (wr_irq_clr && wdata_r[IRQ_DONE_BIT]) begin
      irq_stat_r[IRQ_DONE_BIT] <= 1'b0;
    end
  end

  // Interrupt enable register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_en_r <= IRQ_RESET;
    end else if (wr_irq_en) begin
      irq_en_r <= wdata_r[IRQ_W-1:0];
    end
  end

  // Level interrupt, registered from status and enable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read decode; reserved bits and the clear register read zero
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      OFS_CONTROL:   rd_byte = ctrl_r;
      OFS_RES_HIGH:  rd_byte = res_high_r;
      OFS_RES_LOW:   rd_byte = res_low_r;
      OFS_IRQ_STAT:  rd_byte = {7'h00, irq_stat_r};
      OFS_IRQ_CLEAR: rd_byte = 8'h00;
      OFS_IRQ_EN:    rd_byte = {7'h00, irq_en_r};
      default: begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Read channel: one read outstanding, data registered at the handshake
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Comparator level crosses in through two flops
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= comparator_in;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // Bit-period divider; restarted on a start so the first period is whole,
  // and frozen while powered down to save switching
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tad_div_r  <= 8'h00;
      tad_tick_r <= 1'b0;
    end else if (!ctrl_r.power || sar_start) begin
      tad_div_r  <= 8'h00;
      tad_tick_r <= 1'b0;
    end else if (tad_div_r == 8'(TAD_CYC - 1)) begin
      tad_div_r  <= 8'h00;
      tad_tick_r <= 1'b1;
    end else begin
      tad_div_r  <= tad_div_r + 8'h01;
      tad_tick_r <= 1'b0;
    end
  end

  // Front-end drive mirrors the control register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      converter_power_enable  <= 1'b0;
      reference_source_select <= 1'b0;
      input_channel_select    <= 2'h0;
    end else begin
      converter_power_enable  <= ctrl_r.power;
      reference_source_select <= ctrl_r.ref_ext;
      input_channel_select    <= ctrl_r.channel;
    end
  end

  // Successive-approximation sequencer
  adcc_sar u_sar (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .tad_tick  (tad_tick_r),
    .start     (sar_start),
    .abort     (sar_abort),
    .cmp_hi    (cmp_sync_r),
    .done      (sar_done),
    .holdoff   (sar_holdoff),
    .result    (sar_result),
    .dac_code  (dac_code),
    .sample_on (sample_switch_on)
  );

endmodule

`default_nettype wire

// ===== adcc_props.sv
// Port-level checks for the converter control block.
// Bound to adcc_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module adcc_props (
  // Clock and reset
  input wire logic                        ref_clk,
  input wire logic                        reset_n,
  // Register bus
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_rvalid,
  input wire logic [31:0]                 s_axi_rdata,
  // Front end and interrupt
  input wire logic                        converter_power_enable,
  input wire logic                        reference_source_select,
  input wire logic [1:0]                  input_channel_select,
  input wire logic                        sample_switch_on,
  input wire logic                        irq
);
  import adcc_pkg::*;
  logic [7:0] wa_q, wd_q, ra_q;
  logic       ws_q, en_q;
  logic       ctl_hit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Keep each bus item as it is taken
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      {wd_q, ws_q} <= {s_axi_wdata[7:0], s_axi_wstrb[0]};
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  // Enable mirror, one edge behind like irq
  always_ff @(posedge ref_clk) begin
    if (!reset_n) en_q <= 1'b0;
    else if ($rose(s_axi_bvalid) && wa_q == OFS_IRQ_EN && ws_q)
      en_q <= wd_q[0];
  end
  assign ctl_hit = (wa_q == OFS_CONTROL) && ws_q;
  AST_POWER_WR:
    assert property ($rose(s_axi_bvalid) && ctl_hit |=>
      converter_power_enable == wd_q[BIT_POWER]) else $error("power bit");
  AST_REF_WR:
    assert property ($rose(s_axi_bvalid) && ctl_hit |=>
      reference_source_select == wd_q[BIT_REF_EXT]) else $error("ref bit");
  AST_CHAN_WR:
    assert property ($rose(s_axi_bvalid) && ctl_hit |=>
      input_channel_select == wd_q[3:2]) else $error("channel field");
  AST_RD_UNUSED:
    assert property (s_axi_rvalid && ra_q == OFS_CONTROL |->
      s_axi_rdata[5:4] == 2'h0) else $error("unused bits not zero");
  AST_RD_UPPER:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
  AST_SAMPLE_SPAN:
    assert property ($rose(sample_switch_on) |-> sample_switch_on[*8]
      ##[1:40] !sample_switch_on) else $error("sample period length");
  AST_SAMPLE_PWR:
    assert property ($rose(sample_switch_on) |-> converter_power_enable &&
      $past(converter_power_enable, 2)) else $error("start without power");
  AST_OFF_QUIET:
    assert property (!converter_power_enable[*3] |-> !sample_switch_on)
      else $error("sampling while off");
  AST_IRQ_GATE:
    assert property (irq |-> en_q) else $error("irq while disabled");
endmodule
bind adcc_top adcc_props u_adcc_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .irq(irq),
  .converter_power_enable(converter_power_enable),
  .reference_source_select(reference_source_select),
  .input_channel_select(input_channel_select),
  .sample_switch_on(sample_switch_on));
`default_nettype wire

// ===== adcc_partner.sv
// Analog side: four inputs, two references and the comparator.
// Assumes the trial code settles well inside one bit period.
`timescale 1ns/1ps
`default_nettype none
module adcc_partner #(
  parameter int SUPPLY_MV = 5000
) (
  // Clock
  input wire logic                       ref_clk,
  // Drive from the block
  input wire logic                       converter_power_enable,
  input wire logic                       reference_source_select,
  input wire logic [1:0]                 input_channel_select,
  input wire logic [adcc_pkg::RES_W-1:0] dac_code,
  // Analog levels in millivolts
  input wire logic [3:0][12:0]           chan_mv,
  input wire logic [12:0]                ext_mv,
  // Comparator
  output logic                           comparator_in
);
  import adcc_pkg::*;
  int unsigned vin, vref;
  logic        tgl = 1'b0;
  // Input routing and reference choice
  always_comb begin
    vin = chan_mv[input_channel_select];
    vref = reference_source_select ? ext_mv : SUPPLY_MV;
  end
  // Unpowered comparator flickers, so a stale level is never read
  always_ff @(posedge ref_clk) begin
    tgl <= ~tgl;
  end
  assign comparator_in = converter_power_enable ?
    (vin * 1024 >= dac_code * vref) : tgl;
endmodule
`default_nettype wire

// ===== adcc_top_test.sv
// Self-checking bench: bus master, analog levels, reference model.
// Assumes the block's register offsets and conversion contract.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module adcc_top_test;
  import adcc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n, converter_power_enable, reference_source_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, comparator_in, irq, sample_switch_on;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rsp, input_channel_select;
  logic [9:0]       dac_code;
  logic [3:0][12:0] chan_mv;
  logic [12:0]      ext_mv;
  int miscompares = 0, checks = 0, m_ctrl, m_hi, m_lo, m_en, code;
  logic [7:0] m_ctrl_offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  adcc_top u_adcc_top (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .comparator_in(comparator_in),
    .converter_power_enable(converter_power_enable),
    .reference_source_select(reference_source_select),
    .input_channel_select(input_channel_select),
    .sample_switch_on(sample_switch_on), .dac_code(dac_code), .irq(irq));
  adcc_partner u_adcc_partner (.ref_clk(ref_clk),
    .converter_power_enable(converter_power_enable),
    .reference_source_select(reference_source_select),
    .input_channel_select(input_channel_select), .dac_code(dac_code),
    .chan_mv(chan_mv), .ext_mv(ext_mv), .comparator_in(comparator_in));
  // Free-running system clock
  always #50 ref_clk = ~ref_clk;
  // Master: answers are taken at the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'h1);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, input int e);
    rd_reg(a);
    `CHK(nm, e, rd)
  endtask
  // Configure, start, poll, compare with the model
  task automatic convert(input int ch, input int rj, input int ext);
    int n;
    m_ctrl = (rj << 7) | (ext << 6) | (ch << 2) | 1;
    wr(OFS_CONTROL, m_ctrl[7:0]);
    wr(OFS_CONTROL, m_ctrl[7:0] | 8'h02);
    @(negedge ref_clk);
    `CHK("sample", 1, sample_switch_on)
    `CHK("chan", ch, input_channel_select)
    `CHK("ref", ext, reference_source_select)
    n = 0;
    do rd_reg(OFS_CONTROL); while (rd[1] === 1'b1 && ++n < 200);
    `CHK("go", m_ctrl, rd)
    code = int'(chan_mv[ch]) * 1024 / (ext ? int'(ext_mv) : 5000);
    if (code > 1023) code = 1023;
    m_hi = rj ? code >> 8 : code >> 2;
    m_lo = rj ? code & 255 : (code & 3) << 6;
    chk_reg("res_high", OFS_RES_HIGH, m_hi);
    chk_reg("res_low", OFS_RES_LOW, m_lo);
    chk_reg("status", OFS_IRQ_STAT, 1);
    `CHK("irq", m_en, irq)
    wr(OFS_IRQ_CLEAR, 8'h01);
    @(negedge ref_clk);
    `CHK("irq_clr", 0, irq)
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     reset_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    chan_mv = '0;
    ext_mv = 13'h0fa0;
    m_en = 0;
    void'($urandom(32'he7d92b16));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (m_ctrl_offs[i]) chk_reg("reset", m_ctrl_offs[i], 0);
    rd_reg(8'h20);
    `CHK("rd_unmapped", RESP_SLVERR, rsp)
    wr(8'h20, 8'hff);
    `CHK("wr_unmapped", RESP_SLVERR, rsp)
    wr(OFS_CONTROL, 8'hff);
    chk_reg("ctrl", OFS_CONTROL, 8'hcd);
    `CHK("power", 1, converter_power_enable)
    wr(OFS_CONTROL, 8'h00, 4'h0);
    wr(OFS_RES_HIGH, 8'hff);
    chk_reg("ctrl_nostrb", OFS_CONTROL, 8'hcd);
    chk_reg("res_ro", OFS_RES_HIGH, 0);
    for (int i = 0; i < 8; i++) begin
      chan_mv[i % 4] <= 13'($urandom_range(0, 5000));
      ext_mv <= 13'($urandom_range(2000, 5000));
      m_en = i % 2;
      wr(OFS_IRQ_EN, m_en[7:0]);
      convert(i % 4, i / 4, $urandom % 2);
    end
    // Abort: old result kept, starts dropped in the gap
    wr(OFS_CONTROL, 8'h83);
    repeat (50) @(posedge ref_clk);
    wr(OFS_CONTROL, 8'h81);
    wr(OFS_CONTROL, 8'h83);
    chk_reg("abort_go", OFS_CONTROL, 8'h81);
    chk_reg("abort_high", OFS_RES_HIGH, m_hi);
    chk_reg("abort_low", OFS_RES_LOW, m_lo);
    chk_reg("abort_stat", OFS_IRQ_STAT, 0);
    repeat (45) @(posedge ref_clk);
    convert(2, 1, 0);
    wr(OFS_CONTROL, 8'h00);
    repeat (4) @(posedge ref_clk);
    `CHK("power_off", 0, converter_power_enable)
    give_verdict();
  end
endmodule
`default_nettype wire
